// [rtl/vevr_pkg.sv]
// package: offsets, field layout and reset values of the alarm routing block
package vevr_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned LO_W   = 8;
  localparam int unsigned HI_W   = 3;
  localparam int unsigned CODE_W = 5;
  localparam int unsigned SYNC_STAGES = 3;

  localparam logic [ADDR_W-1:0] OFS_SMI_LO    = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_SMI_HI    = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_LO    = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_HI    = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_CODE      = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_STS_LO    = 4'hA;
  localparam logic [ADDR_W-1:0] OFS_STS_HI    = 4'hB;
  localparam logic [ADDR_W-1:0] OFS_MASK_LO   = 4'hC;
  localparam logic [ADDR_W-1:0] OFS_MASK_HI   = 4'hD;

  localparam int unsigned SEL_POS = 6;
  localparam int unsigned SEL_W   = 2;
  localparam logic [SEL_W-1:0] SEL_CPU0 = 2'h0;
  localparam logic [SEL_W-1:0] SEL_CPU1 = 2'h1;

  localparam logic [LO_W-1:0]  RST_LO   = 8'h00;
  localparam logic [HI_W-1:0]  RST_HI   = 3'h0;
  localparam logic [SEL_W-1:0] RST_SEL  = 2'h0;
  localparam logic [CODE_W-1:0] RST_CODE = 5'h00;
  localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;
endpackage

// [rtl/vevr_sync.sv]
// three-stage synchroniser with agreement filter for a pin bus
`timescale 1ns/1ps
module vevr_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // pin side
  input  wire logic [W-1:0] pin_in,
  // synchronised side
  output logic      [W-1:0] level_out
);
  import vevr_pkg::*;

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit changes only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          level_out[g] <= 1'b0;
        end else if (s2_r[g] == s3_r[g]) begin
          level_out[g] <= s3_r[g];
        end
      end
    end
  endgenerate
endmodule

// [rtl/vevr_top.sv]
// voltage alarm routing to smi/irq with cpu voltage code readout
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module vevr_top
  import vevr_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // register port
  input  wire logic [vevr_pkg::ADDR_W-1:0] addr,
  input  wire logic [vevr_pkg::DATA_W-1:0] wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic      [vevr_pkg::DATA_W-1:0] rdata,
  // alarm levels from the monitor, same clock
  input  wire logic [vevr_pkg::LO_W-1:0]   alarm_lo,
  input  wire logic [vevr_pkg::HI_W-1:0]   alarm_hi,
  // cpu voltage code pins, already routed at chip level
  input  wire logic [vevr_pkg::CODE_W-1:0] cpu_voltage_code_route_a,
  input  wire logic [vevr_pkg::CODE_W-1:0] cpu_voltage_code_route_b,
  // requests
  output logic                             smi_req,
  output logic                             irq_req,
  output logic                             int_out
);
  import vevr_pkg::*;

  logic [LO_W-1:0]   smi_lo_r;
  logic [HI_W-1:0]   smi_hi_r;
  logic [LO_W-1:0]   irq_lo_r;
  logic [HI_W-1:0]   irq_hi_r;
  logic [SEL_W-1:0]  sel_r;
  logic [LO_W-1:0]   sts_lo_r;
  logic [HI_W-1:0]   sts_hi_r;
  logic [LO_W-1:0]   mask_lo_r;
  logic [HI_W-1:0]   mask_hi_r;
  logic [LO_W-1:0]   alarm_lo_d_r;
  logic [HI_W-1:0]   alarm_hi_d_r;
  logic [CODE_W-1:0] code_a;
  logic [CODE_W-1:0] code_b;
  logic [CODE_W-1:0] code_sel;
  logic [DATA_W-1:0] rdata_nxt;
  logic [LO_W-1:0]   rise_lo;
  logic [HI_W-1:0]   rise_hi;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs,
                               input logic              stb);
    hit = stb && (a == ofs);
  endfunction

  // pins come from another domain; route choice lives at chip level
  vevr_sync #(.W(CODE_W)) u_sync_a (
    .clk       (clk),
    .nrst      (nrst),
    .pin_in    (cpu_voltage_code_route_a),
    .level_out (code_a)
  );
  vevr_sync #(.W(CODE_W)) u_sync_b (
    .clk       (clk),
    .nrst      (nrst),
    .pin_in    (cpu_voltage_code_route_b),
    .level_out (code_b)
  );

  // reserved select codes report cpu0 rather than garbage
  assign code_sel = (sel_r == SEL_CPU1) ? code_b : code_a;

  // smi routing enables
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      smi_lo_r <= RST_LO;
    end else if (hit(addr, OFS_SMI_LO, wr)) begin
      smi_lo_r <= wdata[LO_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      smi_hi_r <= RST_HI;
    end else if (hit(addr, OFS_SMI_HI, wr)) begin
      smi_hi_r <= wdata[HI_W-1:0];
    end
  end

  // irq routing enables
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_lo_r <= RST_LO;
    end else if (hit(addr, OFS_IRQ_LO, wr)) begin
      irq_lo_r <= wdata[LO_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_hi_r <= RST_HI;
    end else if (hit(addr, OFS_IRQ_HI, wr)) begin
      irq_hi_r <= wdata[HI_W-1:0];
    end
  end

  // cpu select field
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_r <= RST_SEL;
    end else if (hit(addr, OFS_CODE, wr)) begin
      sel_r <= wdata[SEL_POS +: SEL_W];
    end
  end

  // interrupt mask
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_lo_r <= RST_LO;
      mask_hi_r <= RST_HI;
    end else begin
      if (hit(addr, OFS_MASK_LO, wr)) begin
        mask_lo_r <= wdata[LO_W-1:0];
      end
      if (hit(addr, OFS_MASK_HI, wr)) begin
        mask_hi_r <= wdata[HI_W-1:0];
      end
    end
  end

  // alarm onset detection for the sticky latch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarm_lo_d_r <= RST_LO;
      alarm_hi_d_r <= RST_HI;
    end else begin
      alarm_lo_d_r <= alarm_lo;
      alarm_hi_d_r <= alarm_hi;
    end
  end

  assign rise_lo = alarm_lo & ~alarm_lo_d_r;
  assign rise_hi = alarm_hi & ~alarm_hi_d_r;

  // sticky event latch, write one to clear; a new onset beats the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sts_lo_r <= RST_LO;
      sts_hi_r <= RST_HI;
    end else begin
      sts_lo_r <= (sts_lo_r & ~(hit(addr, OFS_STS_LO, wr) ?
                   wdata[LO_W-1:0] : RST_LO)) | rise_lo;
      sts_hi_r <= (sts_hi_r & ~(hit(addr, OFS_STS_HI, wr) ?
                   wdata[HI_W-1:0] : RST_HI)) | rise_hi;
    end
  end

  // smi/irq routing follows the live alarm level so it drops when back in limits; int_out follows the sticky latch
  assign smi_req = |(alarm_lo & smi_lo_r) | |(alarm_hi & smi_hi_r);
  assign irq_req = |(alarm_lo & irq_lo_r) | |(alarm_hi & irq_hi_r);
  assign int_out = |(sts_lo_r & mask_lo_r) | |(sts_hi_r & mask_hi_r);

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = RST_RDATA;
    case (addr)
      OFS_SMI_LO:  rdata_nxt = smi_lo_r;
      OFS_SMI_HI:  rdata_nxt = {{(DATA_W-HI_W){1'b0}}, smi_hi_r};
      OFS_IRQ_LO:  rdata_nxt = irq_lo_r;
      OFS_IRQ_HI:  rdata_nxt = {{(DATA_W-HI_W){1'b0}}, irq_hi_r};
      OFS_CODE:    rdata_nxt = {sel_r, 1'b0, code_sel};
      OFS_STS_LO:  rdata_nxt = sts_lo_r;
      OFS_STS_HI:  rdata_nxt = {{(DATA_W-HI_W){1'b0}}, sts_hi_r};
      OFS_MASK_LO: rdata_nxt = mask_lo_r;
      OFS_MASK_HI: rdata_nxt = {{(DATA_W-HI_W){1'b0}}, mask_hi_r};
      4'h0:        rdata_nxt = alarm_lo;
      4'h1:        rdata_nxt = {{(DATA_W-HI_W){1'b0}}, alarm_hi};
      default:     rdata_nxt = RST_RDATA;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= RST_RDATA;
    end else if (rd) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= RST_RDATA;
    end
  end
endmodule

// [bench/vevr_checker.sv]
// checker: bus and request relations of the alarm routing block
`timescale 1ns/1ps
module vevr_checker
  import vevr_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  // alarms and code pins
  input wire logic [LO_W-1:0]   alarm_lo,
  input wire logic [HI_W-1:0]   alarm_hi,
  input wire logic [CODE_W-1:0] cpu_voltage_code_route_a,
  input wire logic [CODE_W-1:0] cpu_voltage_code_route_b,
  // requests
  input wire logic              smi_req,
  input wire logic              irq_req,
  input wire logic              int_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence wr_rd(a);
    wr && addr == a ##2 rd && addr == a;
  endsequence
  a_live_lo_read: assert property ($past(rd && addr == 4'h0) |->
    rdata == $past(alarm_lo)) else $error("live alarm lo readout");
  a_live_hi_read: assert property ($past(rd && addr == 4'h1) |->
    rdata == {5'h00, $past(alarm_hi)}) else $error("live alarm hi readout");
  a_code_rsvd: assert property ($past(rd && addr == OFS_CODE) |->
    !rdata[5]) else $error("code reserved bit set");
  a_hi_rsvd: assert property ($past(rd && addr inside {4'h3, 4'h5})
    |-> rdata[7:3] == 5'h00) else $error("reserved enable bits set");
  a_quiet_req: assert property (alarm_lo == 8'h00 &&
    alarm_hi == 3'h0 |-> !smi_req && !irq_req) else $error("request idle");
  a_smi_back: assert property (wr_rd(OFS_SMI_LO) |=>
    rdata == $past(wdata, 3)) else $error("smi enable lo readback");
  a_irq_back: assert property (wr_rd(OFS_IRQ_LO) |=>
    rdata == $past(wdata, 3)) else $error("irq enable lo readback");
  a_sel_back: assert property (wr_rd(OFS_CODE) |=>
    rdata[7:6] == $past(wdata[7:6], 3)) else $error("select readback");
  c_smi: cover property (smi_req);
  c_irq: cover property (irq_req);
  c_int: cover property (int_out);
endmodule

// [bench/tb.sv]
// testbench: random and corner traffic on the alarm routing block
`timescale 1ns/1ps
module tb;
  import vevr_pkg::*;
  logic       clk, nrst, wr, rd, smi_req, irq_req, int_out;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, alo, slo, ilo, d;
  logic [2:0] ahi, shi, ihi;
  logic [4:0] ca, cb;
  int         num_errors, compares;
  vevr_top dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .alarm_lo(alo), .alarm_hi(ahi),
    .cpu_voltage_code_route_a(ca), .cpu_voltage_code_route_b(cb),
    .smi_req(smi_req), .irq_req(irq_req), .int_out(int_out));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic chk(logic [7:0] g, logic [7:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wreg(logic [3:0] a, logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  function automatic logic rq(logic [7:0] l, logic [2:0] h);
    return |(alo & l) | |(ahi & h);
  endfunction
  task automatic test_done;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #50000;
    num_errors++;
    test_done();
  end
  initial begin
    d = $urandom(51);
    {nrst, wr, rd, addr, wdata, alo, ahi} = '0;
    ca = 5'h15;
    cb = 5'h0a;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 2; i < 6; i++) rreg(4'(i), 8'h00);
    rreg(OFS_CODE, {3'h0, ca});
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      wreg(4'(2 + i % 4), d);
      rreg(4'(2 + i % 4), (i % 2) ? d & 8'h07 : d);
    end
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      ca <= 5'($urandom);
      cb <= 5'($urandom);
      repeat (8) @(posedge clk);
      wreg(OFS_CODE, {2'(s), 6'h3f});
      rreg(OFS_CODE, {2'(s), 1'b0, (s == 1) ? cb : ca});
    end
    for (int i = 0; i < 24; i++) begin
      {slo, shi, ilo, ihi} = 22'({$urandom, $urandom});
      wreg(OFS_SMI_LO, slo);
      wreg(OFS_SMI_HI, {5'h00, shi});
      wreg(OFS_IRQ_LO, ilo);
      wreg(OFS_IRQ_HI, {5'h00, ihi});
      @(posedge clk);
      alo <= (i % 4 == 0) ? 8'h00 : 8'($urandom);
      ahi <= 3'($urandom);
      @(posedge clk);
      #1 chk({7'h00, smi_req}, {7'h00, rq(slo, shi)});
      chk({7'h00, irq_req}, {7'h00, rq(ilo, ihi)});
      chk({7'h00, int_out}, 8'h00);
      rreg(4'h0, alo);
    end
    @(posedge clk);
    {alo, ahi} <= '0;
    wreg(OFS_STS_LO, 8'hff);
    wreg(OFS_STS_HI, 8'h07);
    wreg(OFS_MASK_LO, 8'h10);
    @(posedge clk);
    alo <= 8'h30;
    repeat (3) @(posedge clk);
    #1 chk({7'h00, int_out}, 8'h01);
    rreg(OFS_STS_LO, 8'h30);
    wreg(OFS_MASK_LO, 8'h01);
    #1 chk({7'h00, int_out}, 8'h00);
    wreg(OFS_MASK_LO, 8'h10);
    wreg(OFS_STS_LO, 8'h10);
    rreg(OFS_STS_LO, 8'h20);
    chk({7'h00, int_out}, 8'h00);
    // unmapped place keeps nothing
    wreg(4'he, 8'hff);
    rreg(4'he, 8'h00);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rreg(OFS_IRQ_HI, 8'h00);
    test_done();
  end
endmodule
bind vevr_top vevr_checker u_chk (.clk(clk), .nrst(nrst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .alarm_lo(alarm_lo),
  .alarm_hi(alarm_hi), .cpu_voltage_code_route_a(cpu_voltage_code_route_a),
  .cpu_voltage_code_route_b(cpu_voltage_code_route_b), .smi_req(smi_req),
  .irq_req(irq_req), .int_out(int_out));
